// ---- verilog/mac_slice_pkg.sv ----
// Purpose: Shared constants for the multi-instruction multiply/add datapath.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes:   Opmode code is z[6:4], y[3:2], x[1:0].
package mac_slice_pkg;

  // ==========================================================================
  // Datapath widths
  localparam int OPW      = 18;
  localparam int ABW      = 36;
  localparam int PW       = 48;
  localparam int NSLOT    = 8;
  localparam int IDXW     = 3;
  localparam int SHIFT_R  = 17;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] SLOT_BASE   = 8'h20;

  // Control register fields and reset value
  localparam int CTRL_CNT_LSB  = 0;
  localparam int CTRL_EXT_BIT  = 4;
  localparam int CTRL_SUM_EN   = 5;
  localparam int CTRL_A_EN     = 6;
  localparam int CTRL_B_EN     = 7;
  localparam logic [7:0] CTRL_RESET = 8'h11;

  // Instruction slot fields and reset value
  localparam int SLOT_SUB_BIT  = 7;
  localparam int SLOT_CASCADE_B_IN_BIT = 8;
  localparam logic [8:0] SLOT_RESET = 9'h000;

  // ==========================================================================
  // Opmode multiplexer codes
  localparam logic [1:0] X_ZERO = 2'h0;
  localparam logic [1:0] X_MULT = 2'h1;
  localparam logic [1:0] X_P    = 2'h2;
  localparam logic [1:0] X_AB   = 2'h3;
  localparam logic [1:0] Y_C    = 2'h3;
  localparam logic [2:0] Z_ZERO = 3'h0;
  localparam logic [2:0] Z_CAS  = 3'h1;
  localparam logic [2:0] Z_P    = 3'h2;
  localparam logic [2:0] Z_C    = 3'h3;
  localparam logic [2:0] Z_CAS_SHR = 3'h5;
  localparam logic [2:0] Z_P_SHR   = 3'h6;

  // ==========================================================================
  // Pipeline latencies in clock cycles
  localparam logic [2:0] LAT_EXT_MULT = 3'h4;
  localparam logic [2:0] LAT_EXT_ADD  = 3'h3;
  localparam logic [2:0] LAT_NO_EXT   = 3'h2;

endpackage : mac_slice_pkg

// ---- verilog/mac_slice.sv ----
// Purpose: Multiply/add datapath running one of up to eight instructions per cycle.
// Assumes: Operands come from logic on pclk; registers reached over APB.
// Notes:   Results also enter a 16-word FIFO whose fullness stalls the pipeline.
//
// Summary of operation
// - opmode_index picks the instruction at that list position, first is 0.
// - index used only with more than one instruction; else the single one runs.
// - adder operations feed A and B joined as one signed 36-bit value.
// - multiplier operations form signed 18-bit A times signed 18-bit B.
// - adder or multiplier mode follows from the configured instructions.
// - opmodes 0x10-0x1f add cascade_sum_in from a neighbouring slice.
// - opmodes 0x50-0x5f add cascade_sum_in shifted arithmetically right by 17.
// - opmodes 0x60-0x6f add own result shifted right by 17.
// - instructions using cascade_b_in take B from that input.
// - carry_input is added in every opmode except 0x00.
// - global_reset clears pipeline, result, cascade and FIFO registers together; control and slot registers keep their values.
// - with global_clock_enable low every pipeline and result register holds; the FIFO still drains.
// - a C-only instruction presents C plus carry_input on result_out after latency.
// - multiply-add instruction outputs A times B plus C.
// - cascade outputs carry values only when enabled, zero otherwise; result_out always driven.
// - one to eight instructions may be configured.
// - with external registers latency is 4 with multiplier, 3 without.
// - without external registers latency is 2 and no multiplier register.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Result FIFO with registered head
module result_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       clr,
  input  wire logic                       s_valid,
  output logic                            s_ready,
  input  wire logic [WIDTH-1:0]           s_data,
  output logic                            m_valid,
  input  wire logic                       m_ready,
  output logic [WIDTH-1:0]                m_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             vld_r;
  logic [WIDTH-1:0] dat_r;

  wire push = s_valid && s_ready;
  wire load = (cnt_r != '0) && (!vld_r || m_ready);

  assign s_ready = (cnt_r != (AW+1)'(DEPTH));
  assign m_valid = vld_r;
  assign m_data  = dat_r;
  assign level   = cnt_r;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_r] <= s_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      vld_r <= 1'b0;
      dat_r <= '0;
    end else if (clr) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      vld_r <= 1'b0;
      dat_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (load) begin
        rd_r  <= rd_r + 1'b1;
        dat_r <= mem[rd_r];
        vld_r <= 1'b1;
      end else if (m_ready) begin
        vld_r <= 1'b0;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule : result_fifo

// ============================================================================
// Datapath top
module mac_slice (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic [31:0]                               prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 global_reset,
  input  wire logic                                 global_clock_enable,
  input  wire logic                                 op_valid,
  input  wire logic [mac_slice_pkg::IDXW-1:0]       opmode_index,
  input  wire logic [mac_slice_pkg::OPW-1:0]        a_in,
  input  wire logic [mac_slice_pkg::OPW-1:0]        b_in,
  input  wire logic [mac_slice_pkg::PW-1:0]         c_in,
  input  wire logic                                 carry_input,
  input  wire logic [mac_slice_pkg::PW-1:0]         cascade_sum_in,
  input  wire logic [mac_slice_pkg::OPW-1:0]        cascade_b_in,
  output logic [mac_slice_pkg::PW-1:0]              result_out,
  output logic                                      result_valid,
  output logic [mac_slice_pkg::PW-1:0]              cascade_sum_out,
  output logic [mac_slice_pkg::OPW-1:0]             cascade_a_out,
  output logic [mac_slice_pkg::OPW-1:0]             cascade_b_out,
  output logic                                      fifo_valid,
  input  wire logic                                 fifo_ready,
  output logic [mac_slice_pkg::PW-1:0]              fifo_data
);
  import mac_slice_pkg::*;

  // Arithmetic right shift by 17 of a 48-bit value.
  function automatic logic [PW-1:0] shr17(input logic [PW-1:0] v);
    shr17 = PW'($signed(v) >>> SHIFT_R);
  endfunction : shr17

  // Sign extension of a 36-bit value to the result width.
  function automatic logic [PW-1:0] sext36(input logic [ABW-1:0] v);
    sext36 = {{(PW-ABW){v[ABW-1]}}, v};
  endfunction : sext36

  // ==========================================================================
  // Register file
  // Every access gets one wait state: pready rises the cycle after the first
  // access edge, so a write lands and read data stands on that second edge.
  // Unmapped offsets and writes to the status word answer with an error.
  logic [7:0]  ctrl_r;
  logic [8:0]  slot_r [NSLOT];
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic [4:0]  fifo_level;
  logic        fifo_s_ready;

  wire        apb_access = psel && penable && !pready_r;
  wire        apb_commit = psel && penable && pready_r && pwrite && !pslverr_r;
  wire        is_ctrl    = (paddr == CTRL_ADDR);
  wire        is_status  = (paddr == STATUS_ADDR);
  wire        is_slot    = (paddr[7:5] == SLOT_BASE[7:5]) && (paddr[1:0] == 2'h0);
  wire [2:0]  slot_sel   = paddr[4:2];
  wire        addr_ok    = is_ctrl || is_status || is_slot;

  // Instruction count limited to 1..8.
  wire [3:0]  cnt_raw    = ctrl_r[CTRL_CNT_LSB +: 4];
  wire [3:0]  cnt_eff    = (cnt_raw == 4'h0) ? 4'h1 :
                           (cnt_raw > 4'h8) ? 4'h8 : cnt_raw;
  wire        ext_regs   = ctrl_r[CTRL_EXT_BIT];

  // Multiplier mode when any configured instruction uses the multiplier.
  // A mixed list takes the longer latency, so adder results arrive late too.
  // Changing the list while results are in flight misaligns them.
  logic mult_mode;
  always_comb begin
    mult_mode = 1'b0;
    for (int i = 0; i < NSLOT; i++) begin
      if ((4'(i) < cnt_eff) && (slot_r[i][1:0] == X_MULT)) begin
        mult_mode = 1'b1;
      end
    end
  end

  wire [2:0] latency = !ext_regs ? LAT_NO_EXT :
                       mult_mode ? LAT_EXT_MULT : LAT_EXT_ADD;

  wire [31:0] rd_mux = is_ctrl   ? {24'h000000, ctrl_r} :
                       is_status ? {19'h00000, !fifo_s_ready, fifo_level,
                                    latency, mult_mode, 3'h0} :
                       is_slot   ? {23'h000000, slot_r[slot_sel]} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_access;
      prdata_r  <= apb_access ? rd_mux : 32'h00000000;
      pslverr_r <= apb_access && (!addr_ok || (pwrite && is_status));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
      for (int i = 0; i < NSLOT; i++) begin
        slot_r[i] <= SLOT_RESET;
      end
    end else if (apb_commit) begin
      if (is_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
      if (is_slot) begin
        slot_r[slot_sel] <= pwdata[8:0];
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ==========================================================================
  // Instruction selection at entry
  // An index at or beyond the configured count falls back to the first slot,
  // so a stray select value never runs an unconfigured instruction.
  wire [IDXW-1:0] idx_eff = ((cnt_eff == 4'h1) || ({1'b0, opmode_index} >= cnt_eff)) ?
                            '0 : opmode_index;
  wire [8:0]      sel_ins = slot_r[idx_eff];
  wire [OPW-1:0]  b_src   = sel_ins[SLOT_CASCADE_B_IN_BIT] ? cascade_b_in : b_in;

  // Operand bundle entering the pipeline; the instruction rides with it.
  localparam int BW = 1 + 8 + 1 + OPW + OPW + PW + PW;
  wire [BW-1:0] entry = {op_valid, sel_ins[7:0], carry_input, a_in, b_src,
                         c_in, cascade_sum_in};

  // Pipeline advances only with the clock enable and room in the FIFO.
  wire adv = global_clock_enable && fifo_s_ready;

  // Three alignment stages cover the longest latency; shorter latencies tap
  // the chain earlier, so operands and their instruction always leave together.
  // The whole chain stalls as one, which keeps that pairing under back-pressure.
  logic [BW-1:0] stage_r [3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        stage_r[i] <= '0;
      end
    end else if (global_reset) begin
      for (int i = 0; i < 3; i++) begin
        stage_r[i] <= '0;
      end
    end else if (adv) begin
      stage_r[0] <= entry;
      stage_r[1] <= stage_r[0];
      stage_r[2] <= stage_r[1];
    end
  end

  // Tap sits latency-1 stages down; the result register adds the last one.
  wire [1:0]    tap_sel = 2'(latency - 3'h2);
  wire [BW-1:0] tap     = stage_r[tap_sel];

  wire             t_valid = tap[BW-1];
  wire [6:0]       t_op    = tap[BW-3 -: 7];
  wire             t_sub   = tap[BW-2];
  wire             t_cin   = tap[2*OPW+2*PW];
  wire [OPW-1:0]   t_a     = tap[OPW+2*PW +: OPW];
  wire [OPW-1:0]   t_b     = tap[2*PW +: OPW];
  wire [PW-1:0]    t_c     = tap[PW +: PW];
  wire [PW-1:0]    t_cas   = tap[0 +: PW];

  wire [1:0] x_code = t_op[1:0];
  wire [1:0] y_code = t_op[3:2];
  wire [2:0] z_code = t_op[6:4];

  // ==========================================================================
  // Arithmetic
  logic [PW-1:0] p_r;
  logic          p_valid_r;

  wire [ABW-1:0] ab_cat  = {t_a, t_b};
  wire [ABW-1:0] product = ABW'($signed(t_a) * $signed(t_b));

  logic [PW-1:0] x_val;
  logic [PW-1:0] y_val;
  logic [PW-1:0] z_val;

  always_comb begin
    unique case (x_code)
      X_ZERO: x_val = '0;
      X_MULT: x_val = sext36(product);
      X_P:    x_val = p_r;
      X_AB:   x_val = sext36(ab_cat);
    endcase
  end

  assign y_val = (y_code == Y_C) ? t_c : '0;

  always_comb begin
    case (z_code)
      Z_CAS:     z_val = t_cas;
      Z_P:       z_val = p_r;
      Z_C:       z_val = t_c;
      Z_CAS_SHR: z_val = shr17(t_cas);
      Z_P_SHR:   z_val = shr17(p_r);
      default:   z_val = '0;
    endcase
  end

  // Subtraction removes the carry together with X and Y, so the carry always
  // moves the result towards the operand sum and never against it.
  wire [PW-1:0] cin_val = (t_op == 7'h00) ? '0 : PW'(t_cin);
  wire [PW-1:0] xyc     = x_val + y_val + cin_val;
  wire [PW-1:0] p_nxt   = t_sub ? (z_val - xyc) : (z_val + xyc);

  // Disabled cascade outputs are held at zero rather than left floating, so a
  // neighbour wired to them sees a defined value.
  logic [PW-1:0]  sum_out_r;
  logic [OPW-1:0] a_out_r;
  logic [OPW-1:0] b_out_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_r       <= '0;
      p_valid_r <= 1'b0;
      sum_out_r <= '0;
      a_out_r   <= '0;
      b_out_r   <= '0;
    end else if (global_reset) begin
      p_r       <= '0;
      p_valid_r <= 1'b0;
      sum_out_r <= '0;
      a_out_r   <= '0;
      b_out_r   <= '0;
    end else if (adv) begin
      p_r       <= p_nxt;
      p_valid_r <= t_valid;
      sum_out_r <= ctrl_r[CTRL_SUM_EN] ? p_nxt : '0;
      a_out_r   <= ctrl_r[CTRL_A_EN] ? t_a : '0;
      b_out_r   <= ctrl_r[CTRL_B_EN] ? t_b : '0;
    end
  end

  assign result_out      = p_r;
  assign result_valid    = p_valid_r;
  assign cascade_sum_out = sum_out_r;
  assign cascade_a_out   = a_out_r;
  assign cascade_b_out   = b_out_r;

  // ==========================================================================
  // Result FIFO; each valid result is queued as it is registered.
  // A full FIFO stops the pipeline even when no valid result is in flight,
  // so a consumer that stops reading also stops new operands being taken.
  result_fifo #(
    .WIDTH (PW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (global_reset),
    .s_valid (adv && t_valid),
    .s_ready (fifo_s_ready),
    .s_data  (p_nxt),
    .m_valid (fifo_valid),
    .m_ready (fifo_ready),
    .m_data  (fifo_data),
    .level   (fifo_level)
  );

endmodule : mac_slice

`default_nettype wire

// ---- testbench/mac_slice_props.sv ----
// Purpose: Port assertions for the multiply/add datapath.
// Assumes: One clock; presetn low clears everything.
// Notes:   Bound to every mac_slice instance.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Checker
module mac_slice_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_reset,
  input wire logic        global_clock_enable,
  input wire logic [47:0] result_out,
  input wire logic        result_valid,
  input wire logic [47:0] cascade_sum_out,
  input wire logic        fifo_valid,
  input wire logic        fifo_ready,
  input wire logic [47:0] fifo_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  ready_wait_a: assert property (access_s |=> answer_s)
    else $error("pready missed its cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero when idle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  clear_all_a: assert property (global_reset |=> result_out == 48'h0 && !result_valid
    && cascade_sum_out == 48'h0 && !fifo_valid) else $error("clear incomplete");
  freeze_a: assert property (!global_clock_enable && !global_reset |=> $stable(result_out))
    else $error("result moved while frozen");
  mirror_sum_a: assert property (cascade_sum_out != 48'h0 |-> cascade_sum_out == result_out)
    else $error("cascade sum differs from result");
  head_hold_a: assert property (fifo_valid && !fifo_ready && !global_reset
    |=> fifo_valid && $stable(fifo_data)) else $error("fifo head changed");
endmodule : mac_slice_props

bind mac_slice mac_slice_props mac_slice_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .global_reset(global_reset), .global_clock_enable(global_clock_enable),
  .result_out(result_out), .result_valid(result_valid), .cascade_sum_out(cascade_sum_out),
  .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data));
`default_nettype wire

// ---- testbench/fabric_partner.sv ----
// Purpose: Neighbour slice and result consumer beside the datapath.
// Assumes: Cascade values come from another slice's registered outputs.
// Notes:   The consumer stops taking results one cycle after stall rises and resumes one cycle after it falls.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Partner
module fabric_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic [47:0] sum_src,
  input  wire logic [17:0] b_src,
  output logic      [47:0] cascade_sum_in,
  output logic      [17:0] cascade_b_in,
  output logic             fifo_ready
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cascade_sum_in <= 48'h0;
      cascade_b_in   <= 18'h0;
      fifo_ready     <= 1'b0;
    end else begin
      cascade_sum_in <= sum_src;
      cascade_b_in   <= b_src;
      fifo_ready     <= !stall;
    end
  end
endmodule : fabric_partner
`default_nettype wire

// ---- testbench/multi_opmode_mac_datapath_tb.sv ----
// Purpose: Self-checking bench for the multiply/add datapath.
// Assumes: The full slot list holds a multiplier, so latency is four.
// Notes:   The neighbour supplies a fixed cascade sum and cascade B.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Bench
module multi_opmode_mac_datapath_tb;
  import mac_slice_pkg::*;
  typedef struct packed {
    logic [2:0]  idx;
    logic [17:0] a;
    logic [17:0] b;
    logic [47:0] c;
    logic        cin;
    logic [47:0] exp;
  } row_t;
  localparam logic [8:0] SLOTS [8] = '{9'h030, 9'h005, 9'h035, 9'h003,
                                       9'h013, 9'h050, 9'h000, 9'h105};
  localparam row_t ROWS [9] = '{
    '{3'h0, 18'h0, 18'h0, 48'h5, 1'b1, 48'h6},
    '{3'h1, 18'h3, 18'h4, 48'h0, 1'b0, 48'hc},
    '{3'h1, 18'h3fffe, 18'h3, 48'h0, 1'b1, 48'hffff_ffff_fffb},
    '{3'h2, 18'h3, 18'h4, 48'h5, 1'b0, 48'h11},
    '{3'h3, 18'h1, 18'h2, 48'h0, 1'b0, 48'h4_0002},
    '{3'h4, 18'h0, 18'h1, 48'h0, 1'b0, 48'h8000_0000_0001},
    '{3'h5, 18'h0, 18'h0, 48'h0, 1'b1, 48'hffff_c000_0001},
    '{3'h6, 18'h0, 18'h0, 48'h5, 1'b1, 48'h0},
    '{3'h7, 18'h2, 18'h9, 48'h0, 1'b0, 48'he}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic        global_reset = 1'b0;
  logic        global_clock_enable = 1'b1;
  logic        op_valid = 1'b0;
  logic        carry_input = 1'b0;
  logic        stall = 1'b0;
  logic [2:0]  opmode_index = 3'h0;
  logic [17:0] a_in = 18'h0;
  logic [17:0] b_in = 18'h0;
  logic [47:0] c_in = 48'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, result_valid, fifo_valid, fifo_ready;
  logic [17:0] cascade_b_in, cascade_a_out, cascade_b_out;
  logic [47:0] cascade_sum_in, result_out, cascade_sum_out, fifo_data;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          pops;

  always #2 pclk = ~pclk;

  mac_slice mac_slice_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_reset(global_reset), .global_clock_enable(global_clock_enable),
    .op_valid(op_valid), .opmode_index(opmode_index), .a_in(a_in), .b_in(b_in), .c_in(c_in),
    .carry_input(carry_input), .cascade_sum_in(cascade_sum_in), .cascade_b_in(cascade_b_in),
    .result_out(result_out), .result_valid(result_valid), .cascade_sum_out(cascade_sum_out),
    .cascade_a_out(cascade_a_out), .cascade_b_out(cascade_b_out), .fifo_valid(fifo_valid),
    .fifo_ready(fifo_ready), .fifo_data(fifo_data));

  fabric_partner fabric_partner_inst (.pclk(pclk), .presetn(presetn), .stall(stall),
    .sum_src(48'h8000_0000_0000), .b_src(18'h7), .cascade_sum_in(cascade_sum_in),
    .cascade_b_in(cascade_b_in), .fifo_ready(fifo_ready));

  task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run(input row_t r, input int lat);
    @(posedge pclk);
    opmode_index <= r.idx;
    a_in         <= r.a;
    b_in         <= r.b;
    c_in         <= r.c;
    carry_input  <= r.cin;
    repeat (lat) @(posedge pclk);
    #1 chk("result_out", result_out, r.exp);
  endtask : run

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1 chk("reset_result", result_out, 48'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl", 48'(rd), 48'(CTRL_RESET));
    apb(1'b0, SLOT_BASE, 32'h0);
    chk("slot0", 48'(rd), 48'(SLOT_RESET));
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped", {15'h0, err, rd}, 48'h1_0000_0000);
    apb(1'b1, STATUS_ADDR, 32'hffff_ffff);
    chk("status_wr", 48'(err), 48'h1);
    apb(1'b1, SLOT_BASE, 32'h30);
    run('{3'h2, 18'h0, 18'h0, 48'h5, 1'b0, 48'h5}, 3);
    for (int i = 1; i < 8; i++) apb(1'b1, SLOT_BASE + 8'(4 * i), 32'(SLOTS[i]));
    apb(1'b1, CTRL_ADDR, 32'h38);
    foreach (ROWS[i]) run(ROWS[i], 4);
    @(posedge pclk);
    opmode_index <= 3'h0;
    c_in         <= 48'h5;
    repeat (3) @(posedge pclk);
    #1 chk("result_old", result_out, 48'he);
    chk("a_out", 48'(cascade_a_out), 48'h0);
    chk("b_out", 48'(cascade_b_out), 48'h0);
    chk("sum_out", cascade_sum_out, 48'he);
    @(posedge pclk);
    #1 chk("result_new", result_out, 48'h5);
    @(posedge pclk);
    global_clock_enable <= 1'b0;
    c_in                <= 48'h9;
    repeat (6) @(posedge pclk);
    #1 chk("frozen", result_out, 48'h5);
    @(posedge pclk);
    global_clock_enable <= 1'b1;
    repeat (4) @(posedge pclk);
    #1 chk("thawed", result_out, 48'h9);
    @(posedge pclk);
    global_reset <= 1'b1;
    @(posedge pclk);
    global_reset <= 1'b0;
    #1 chk("cleared", result_out, 48'h0);
    chk("sum_cleared", cascade_sum_out, 48'h0);
    @(posedge pclk);
    stall    <= 1'b1;
    op_valid <= 1'b1;
    repeat (40) @(posedge pclk);
    op_valid <= 1'b0;
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("full", 48'(rd[12]), 48'h1);
    chk("res_valid", 48'(result_valid), 48'h1);
    pops = 0;
    stall <= 1'b0;
    repeat (60) begin
      @(posedge pclk);
      #1;
      if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
        pops++;
        chk("fifo_data", fifo_data, 48'h9);
      end
    end
    chk("drained", 48'(fifo_valid), 48'h0);
    chk("pops", 48'(pops >= 17), 48'h1);
    report_and_stop();
  end
endmodule : multi_opmode_mac_datapath_tb
`default_nettype wire
